/* logic/pog_pkg.sv */
package pog_pkg;

  // Register bus shape
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;

  // Register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_OUTPUT_GATING   = 16'h0F27;
  localparam logic [ADDR_W-1:0] IDX_TRIGGER_CONTROL = 16'h0F29;
  localparam logic [ADDR_W-1:0] IDX_GATE_CONTROL    = 16'h0F2A;
  localparam logic [ADDR_W-1:0] IDX_OUTPUT_STATUS   = 16'h0F2B;

  localparam logic [ADDR_W-1:0] ADDR_OUTPUT_GATING   = 16'(IDX_OUTPUT_GATING * 4);
  localparam logic [ADDR_W-1:0] ADDR_TRIGGER_CONTROL = 16'(IDX_TRIGGER_CONTROL * 4);
  localparam logic [ADDR_W-1:0] ADDR_GATE_CONTROL    = 16'(IDX_GATE_CONTROL * 4);
  localparam logic [ADDR_W-1:0] ADDR_OUTPUT_STATUS   = 16'(IDX_OUTPUT_STATUS * 4);

  // Reset values
  localparam logic [7:0] RST_OUTPUT_GATING   = 8'h00;
  localparam logic [7:0] RST_TRIGGER_CONTROL = 8'h00;
  localparam logic [7:0] RST_GATE_CONTROL    = 8'h00;

  // Output gating fields: high side of phase n at 2n, low side at 2n+1
  localparam int unsigned GATING_W      = 6;
  localparam logic [7:0]  GATING_WMASK  = 8'h3F;
  localparam int unsigned NUM_PHASES    = 3;

  // Gate control fields
  localparam int unsigned GC_SWITCH_BIT   = 0;
  localparam int unsigned GC_HIGH_OFF_BIT = 1;
  localparam int unsigned GC_LOW_OFF_BIT  = 2;
  localparam logic [7:0]  GC_WMASK        = 8'h07;

  // Trigger control fields
  localparam int unsigned TC_POL_BIT      = 7;
  localparam int unsigned TC_HIGH_ACT_BIT = 6;
  localparam int unsigned TC_HIGH_IDL_BIT = 5;
  localparam int unsigned TC_LOW_ACT_BIT  = 4;
  localparam int unsigned TC_LOW_IDL_BIT  = 3;
  localparam int unsigned TC_SEL_LSB      = 0;

  // Output status fields
  localparam int unsigned ST_HIGH_LSB  = 0;
  localparam int unsigned ST_LOW_LSB   = 3;
  localparam int unsigned ST_LEVEL_BIT = 6;
  localparam int unsigned ST_FAULT_BIT = 7;

endpackage : pog_pkg

/* logic/pog_trig_if.sv */
interface pog_trig_if;
  logic [7:0] cfg;
  logic [2:0] high_lvl;
  logic [2:0] low_lvl;
  logic       level;
  logic       start;

  modport src
  (
    output cfg,
    output high_lvl,
    output low_lvl,
    input  level,
    input  start
  );

  modport trig
  (
    input  cfg,
    input  high_lvl,
    input  low_lvl,
    output level,
    output start
  );
endinterface : pog_trig_if

/* logic/pog_trig.sv */
module pog_trig
(
  // Clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_srst,
  // Match inputs and trigger outputs
  pog_trig_if.trig  trig
);

  typedef struct packed {
    logic level;
    logic prev;
    logic start;
  } pog_trig_s;

  pog_trig_s state_reg;
  pog_trig_s state_next;

  always_comb
  begin
    logic [2:0] sel;
    logic [2:0] h_act;
    logic [2:0] h_idl;
    logic [2:0] l_act;
    logic [2:0] l_idl;
    logic       any_term;
    sel   = trig.cfg[pog_pkg::TC_SEL_LSB +: pog_pkg::NUM_PHASES];
    // Deselected channel reads true in every group
    h_act = ~sel | trig.high_lvl;
    h_idl = ~sel | ~trig.high_lvl;
    l_act = ~sel | trig.low_lvl;
    // Low-idle group uses low-side complements
    l_idl = ~sel | ~trig.low_lvl;
    any_term = (trig.cfg[pog_pkg::TC_HIGH_ACT_BIT] & (&h_act))
             | (trig.cfg[pog_pkg::TC_HIGH_IDL_BIT] & (&h_idl))
             | (trig.cfg[pog_pkg::TC_LOW_ACT_BIT] & (&l_act))
             | (trig.cfg[pog_pkg::TC_LOW_IDL_BIT] & (&l_idl));
    state_next       = state_reg;
    state_next.level = trig.cfg[pog_pkg::TC_POL_BIT] ^ any_term;
    state_next.prev  = state_reg.level;
    // Rising edge only; falling or steady gives nothing
    state_next.start = state_reg.level & ~state_reg.prev;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign trig.level = state_reg.level;
  assign trig.start = state_reg.start;

endmodule : pog_trig

/* logic/pog_top.sv */
// Contract
// - High gating bit 1 holds high pin off
// - Low gating bit 1 holds low pin off
// - Gating acts only while switch bit set
// - Gating never disturbs the modulator itself
// - Fault forces all six outputs off
// - Trigger is polarity XOR OR of groups
// - One conversion start per rising edge
// - Polarity one inverts the trigger sense
// - High-active enable adds AND of highs
// - High-idle enable adds AND of inverted highs
// - Low-active enable adds AND of lows
// - Low-idle enable adds AND of inverted lows
// - Cleared channel select makes its terms true
// - Trigger settings never touch output pins
//
// The implementer's own choice: the address-and-strobe port.
module pog_top
(
  // Clock and reset
  input  wire logic                       i_clk_sys,
  input  wire logic                       i_srst,
  // Register port
  input  wire logic [pog_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [pog_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                       i_wr,
  input  wire logic                       i_rd,
  output logic      [pog_pkg::DATA_W-1:0] o_rdata,
  // Modulator levels and fault
  input  wire logic [2:0]                 i_mod_high,
  input  wire logic [2:0]                 i_mod_low,
  input  wire logic                       i_fault,
  // Output pins
  output logic      [2:0]                 o_pwm_high,
  output logic      [2:0]                 o_pwm_low,
  // Conversion start
  output logic                            o_conv_start,
  output logic                            o_conv_level
);

  typedef struct packed {
    logic [pog_pkg::GATING_W-1:0] gating;
    logic [7:0]                   gate_ctl;
    logic [7:0]                   trig_ctl;
    logic [2:0]                   high_out;
    logic [2:0]                   low_out;
    logic [pog_pkg::DATA_W-1:0]   rdata;
  } pog_top_s;

  pog_top_s   state_reg;
  pog_top_s   state_next;
  logic [2:0] high_gated;
  logic [2:0] low_gated;
  logic       gate_on;
  logic       high_off_lvl;
  logic       low_off_lvl;

  pog_trig_if trig_bus ();

  assign gate_on      = state_reg.gate_ctl[pog_pkg::GC_SWITCH_BIT];
  assign high_off_lvl = state_reg.gate_ctl[pog_pkg::GC_HIGH_OFF_BIT];
  assign low_off_lvl  = state_reg.gate_ctl[pog_pkg::GC_LOW_OFF_BIT];

  // Modulator inputs pass through untouched; only pin selection changes
  genvar ph;
  generate
    for (ph = 0; ph < pog_pkg::NUM_PHASES; ph++)
    begin : g_phase
      // Fault wins over the switch and every gating bit
      assign high_gated[ph] = (i_fault || (gate_on && state_reg.gating[2*ph]))
                              ? high_off_lvl : i_mod_high[ph];
      assign low_gated[ph]  = (i_fault || (gate_on && state_reg.gating[2*ph+1]))
                              ? low_off_lvl : i_mod_low[ph];
    end
  endgenerate

  always_comb
  begin
    state_next          = state_reg;
    state_next.rdata    = '0;
    // Trigger settings do not feed the pin path
    state_next.high_out = high_gated;
    state_next.low_out  = low_gated;
    if (i_wr)
    begin
      unique case (i_addr)
        pog_pkg::ADDR_OUTPUT_GATING:
        begin
          state_next.gating = pog_pkg::GATING_W'(i_wdata & pog_pkg::GATING_WMASK);
        end
        pog_pkg::ADDR_TRIGGER_CONTROL:
        begin
          state_next.trig_ctl = i_wdata;
        end
        pog_pkg::ADDR_GATE_CONTROL:
        begin
          state_next.gate_ctl = i_wdata & pog_pkg::GC_WMASK;
        end
        default:
        begin
          state_next.gating = state_reg.gating;
        end
      endcase
    end
    if (i_rd)
    begin
      unique case (i_addr)
        pog_pkg::ADDR_OUTPUT_GATING:
        begin
          state_next.rdata = {2'h0, state_reg.gating};
        end
        pog_pkg::ADDR_TRIGGER_CONTROL:
        begin
          state_next.rdata = state_reg.trig_ctl;
        end
        pog_pkg::ADDR_GATE_CONTROL:
        begin
          state_next.rdata = state_reg.gate_ctl;
        end
        pog_pkg::ADDR_OUTPUT_STATUS:
        begin
          state_next.rdata[pog_pkg::ST_HIGH_LSB +: 3] = state_reg.high_out;
          state_next.rdata[pog_pkg::ST_LOW_LSB +: 3]  = state_reg.low_out;
          state_next.rdata[pog_pkg::ST_LEVEL_BIT]     = trig_bus.level;
          state_next.rdata[pog_pkg::ST_FAULT_BIT]     = i_fault;
        end
        default:
        begin
          state_next.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      state_reg          <= '0;
      state_reg.gating   <= pog_pkg::GATING_W'(pog_pkg::RST_OUTPUT_GATING);
      state_reg.gate_ctl <= pog_pkg::RST_GATE_CONTROL;
      state_reg.trig_ctl <= pog_pkg::RST_TRIGGER_CONTROL;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Match runs on the levels actually driven on the pins
  assign trig_bus.cfg      = state_reg.trig_ctl;
  assign trig_bus.high_lvl = state_reg.high_out;
  assign trig_bus.low_lvl  = state_reg.low_out;

  pog_trig u_trig
  (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .trig      (trig_bus)
  );

  assign o_rdata      = state_reg.rdata;
  assign o_pwm_high   = state_reg.high_out;
  assign o_pwm_low    = state_reg.low_out;
  assign o_conv_start = trig_bus.start;
  assign o_conv_level = trig_bus.level;

endmodule : pog_top

/* dv/pog_props.sv */
module pog_props
(
  // Watched top ports
  input wire logic        i_clk_sys,
  input wire logic        i_srst,
  input wire logic [15:0] i_addr,
  input wire logic [7:0]  i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [7:0]  o_rdata,
  input wire logic [2:0]  i_mod_high,
  input wire logic [2:0]  i_mod_low,
  input wire logic        i_fault,
  input wire logic [2:0]  o_pwm_high,
  input wire logic [2:0]  o_pwm_low,
  input wire logic        o_conv_start,
  input wire logic        o_conv_level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] og_reg;
  logic [7:0] tc_reg;
  logic [2:0] gc_reg, hg, lg, hi_n, lo_n, ns;
  logic       lvl_n;
  // Shadow of the writable fields, so pin and level checks are exact
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      og_reg <= 6'h00;
      gc_reg <= 3'h0;
      tc_reg <= 8'h00;
    end
    else if (i_wr)
    begin
      if (i_addr == pog_pkg::ADDR_OUTPUT_GATING)
        og_reg <= i_wdata[5:0];
      if (i_addr == pog_pkg::ADDR_GATE_CONTROL)
        gc_reg <= i_wdata[2:0];
      if (i_addr == pog_pkg::ADDR_TRIGGER_CONTROL)
        tc_reg <= i_wdata;
    end
  end
  always_comb
  begin
    hg = {og_reg[4], og_reg[2], og_reg[0]} & {3{gc_reg[0]}};
    lg = {og_reg[5], og_reg[3], og_reg[1]} & {3{gc_reg[0]}};
    hi_n = i_fault ? {3{gc_reg[1]}} : (i_mod_high & ~hg) | ({3{gc_reg[1]}} & hg);
    lo_n = i_fault ? {3{gc_reg[2]}} : (i_mod_low & ~lg) | ({3{gc_reg[2]}} & lg);
    ns = ~tc_reg[2:0];
    lvl_n = tc_reg[7] ^ ((tc_reg[6] & (&(o_pwm_high | ns))) | (tc_reg[4] & (&(o_pwm_low | ns)))
      | (tc_reg[5] & (&(~o_pwm_high | ns))) | (tc_reg[3] & (&(~o_pwm_low | ns))));
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  chk_high_pin_gate: assert property (!$past(i_srst) |-> o_pwm_high == $past(hi_n))
    else $error("high pins wrong");
  chk_low_pin_gate: assert property (!$past(i_srst) |-> o_pwm_low == $past(lo_n))
    else $error("low pins wrong");
  chk_fault_all_off: assert property ($past(i_fault) && !$past(i_srst) |->
    o_pwm_high == {3{$past(gc_reg[1])}} && o_pwm_low == {3{$past(gc_reg[2])}})
    else $error("fault did not force off");
  chk_level_match: assert property (!$past(i_srst) |-> o_conv_level == $past(lvl_n))
    else $error("trigger level wrong");
  chk_start_on_rise: assert property ($rose(o_conv_level) |=> o_conv_start)
    else $error("no start after rise");
  chk_start_one_cycle: assert property (o_conv_start |=> !o_conv_start)
    else $error("start longer than one cycle");
  chk_start_cause: assert property (o_conv_start |-> $past(o_conv_level) &&
    !$past(o_conv_level, 2))
    else $error("start without rise");
  chk_gating_read: assert property ($past(i_rd) && $past(i_addr) ==
    pog_pkg::ADDR_OUTPUT_GATING |-> o_rdata == {2'h0, $past(og_reg)})
    else $error("gating read wrong");
  cover property (o_conv_start);
  cover property (i_fault && gc_reg[0]);
  cover property (gc_reg[0] && og_reg != 6'h00);
endmodule : pog_props

bind pog_top pog_props u_props (.*);

/* dv/pog_adc_model.sv */
module pog_adc_model
(
  // Clock and start
  input  wire logic       i_clk_sys,
  input  wire logic       i_srst,
  input  wire logic       i_conv_start,
  // Conversions begun
  output logic      [7:0] o_conv_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  // One conversion per start pulse; a held start would count once per cycle
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
      o_conv_cnt <= 8'h00;
    else if (i_conv_start)
      o_conv_cnt <= o_conv_cnt + 8'h01;
  end
endmodule : pog_adc_model

/* dv/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] OG = pog_pkg::ADDR_OUTPUT_GATING;
  localparam logic [15:0] TC = pog_pkg::ADDR_TRIGGER_CONTROL;
  localparam logic [15:0] GC = pog_pkg::ADDR_GATE_CONTROL;
  localparam logic [15:0] ST = pog_pkg::ADDR_OUTPUT_STATUS;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        flt = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wd = 8'h00;
  logic [2:0]  mh = 3'h0;
  logic [2:0]  ml = 3'h0;
  logic [7:0]  rdat, cnt, base;
  logic [2:0]  ph, pl;
  logic        cs, cl;
  int          errors = 0;
  int          compares = 0;
  always #50 clk = ~clk;
  pog_top DUT (.i_clk_sys(clk), .i_srst(srst), .i_addr(addr), .i_wdata(wd), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdat), .i_mod_high(mh), .i_mod_low(ml), .i_fault(flt),
    .o_pwm_high(ph), .o_pwm_low(pl), .o_conv_start(cs), .o_conv_level(cl));
  pog_adc_model adc (.i_clk_sys(clk), .i_srst(srst), .i_conv_start(cs), .o_conv_cnt(cnt));
  task automatic stop_test;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e)
    begin
      errors++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task automatic wrr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wrr
  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdat, e);
  endtask : rdc
  // Three edges cover pins, level and the start pulse
  task automatic drv(input logic [2:0] h, input logic [2:0] l, input logic f);
    @(posedge clk);
    mh <= h;
    ml <= l;
    flt <= f;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : drv
  task automatic t_regs;
    rdc(OG, 8'h00);
    rdc(TC, 8'h00);
    wrr(OG, 8'hFF);
    rdc(OG, 8'h3F);
    wrr(TC, 8'hA5);
    rdc(TC, 8'hA5);
    rdc(16'h0010, 8'h00);
    wrr(OG, 8'h00);
  endtask : t_regs
  task automatic t_gate;
    wrr(GC, 8'h01);
    wrr(OG, 8'h15);
    drv(3'h7, 3'h7, 1'b0);
    chk(8'(ph), 8'h00);
    chk(8'(pl), 8'h07);
    wrr(OG, 8'h2A);
    drv(3'h7, 3'h7, 1'b0);
    chk(8'(ph), 8'h07);
    chk(8'(pl), 8'h00);
    wrr(GC, 8'h00);
    drv(3'h5, 3'h2, 1'b0);
    chk(8'(ph), 8'h05);
    chk(8'(pl), 8'h02);
    // Status: no fault, level 1 from high-idle group inverted, pins 2 and 5
    rdc(ST, 8'h55);
    wrr(GC, 8'h01);
    wrr(OG, 8'h00);
    drv(3'h3, 3'h4, 1'b0);
    chk(8'(ph), 8'h03);
    chk(8'(pl), 8'h04);
  endtask : t_gate
  task automatic t_fault;
    wrr(GC, 8'h06);
    drv(3'h0, 3'h0, 1'b1);
    chk(8'(ph), 8'h07);
    chk(8'(pl), 8'h07);
    rdc(GC, 8'h06);
    drv(3'h0, 3'h0, 1'b0);
    chk(8'(ph), 8'h00);
    wrr(GC, 8'h00);
  endtask : t_fault
  task automatic trig(input logic [7:0] t, input logic [2:0] h, input logic [2:0] l,
    input logic e);
    wrr(TC, t);
    drv(h, l, 1'b0);
    chk(8'(cl), 8'(e));
    chk(8'(ph), 8'(h));
  endtask : trig
  task automatic t_trig;
    trig(8'h47, 3'h7, 3'h0, 1'b1);
    trig(8'h27, 3'h0, 3'h7, 1'b1);
    trig(8'h17, 3'h0, 3'h7, 1'b1);
    trig(8'h0F, 3'h7, 3'h0, 1'b1);
    trig(8'hC7, 3'h7, 3'h0, 1'b0);
    trig(8'h46, 3'h6, 3'h0, 1'b1);
    trig(8'h47, 3'h6, 3'h0, 1'b0);
  endtask : t_trig
  // Mid-run reset must drop every setting back to pass-through
  task automatic t_rst;
    wrr(GC, 8'h01);
    wrr(OG, 8'h3F);
    wrr(TC, 8'h47);
    @(posedge clk);
    srst <= 1'b1;
    mh <= 3'h7;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rdc(OG, 8'h00);
    rdc(TC, 8'h00);
    rdc(GC, 8'h00);
    drv(3'h7, 3'h7, 1'b0);
    chk(8'(ph), 8'h07);
    chk(8'(pl), 8'h07);
    chk(8'(cl), 8'h00);
  endtask : t_rst
  task automatic t_start;
    wrr(TC, 8'h47);
    drv(3'h0, 3'h0, 1'b0);
    base = cnt;
    repeat (3)
    begin
      drv(3'h7, 3'h0, 1'b0);
      drv(3'h0, 3'h0, 1'b0);
    end
    drv(3'h0, 3'h0, 1'b0);
    chk(cnt - base, 8'h03);
    chk(8'(cs), 8'h00);
  endtask : t_start
  initial
  begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    t_regs();
    t_gate();
    t_fault();
    t_trig();
    t_start();
    t_rst();
    stop_test();
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    errors++;
    stop_test();
  end
endmodule : tb
